// file: verilog/plc_pkg.sv
/*
  Constants for the parallel line controller: width, register byte offsets,
  reset values and the bus address width.
  Assumes a 32-bit register port with byte addresses, one word per register.
*/
package plc_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int PLC_LINES = 32;
  localparam int PLC_AW = 8;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] PLC_OFS_LEVEL = 8'h00;
  localparam logic [7:0] PLC_OFS_IRQ_EN = 8'h04;
  localparam logic [7:0] PLC_OFS_IRQ_DIS = 8'h08;
  localparam logic [7:0] PLC_OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] PLC_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] PLC_OFS_OD_EN = 8'h14;
  localparam logic [7:0] PLC_OFS_OD_DIS = 8'h18;
  localparam logic [7:0] PLC_OFS_OD_STAT = 8'h1C;
  localparam logic [7:0] PLC_OFS_PU_DIS = 8'h20;
  localparam logic [7:0] PLC_OFS_PU_EN = 8'h24;
  localparam logic [7:0] PLC_OFS_PU_STAT = 8'h28;
  localparam logic [7:0] PLC_OFS_FN_FIRST = 8'h2C;
  localparam logic [7:0] PLC_OFS_FN_SECOND = 8'h30;
  localparam logic [7:0] PLC_OFS_FN_STAT = 8'h34;
  localparam logic [7:0] PLC_OFS_DW_EN = 8'h38;
  localparam logic [7:0] PLC_OFS_DW_DIS = 8'h3C;
  localparam logic [7:0] PLC_OFS_DW_STAT = 8'h40;
  localparam logic [7:0] PLC_OFS_PINS = 8'h44;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] PLC_ZERO = 32'h0000_0000;
  localparam logic [31:0] PLC_RST_LEVEL = 32'h0000_0000;
  localparam logic [31:0] PLC_RST_MASK = 32'h0000_0000;
  localparam logic [31:0] PLC_RST_OD = 32'h0000_0000;
  localparam logic [31:0] PLC_RST_PU_OFF = 32'h0000_0000;
  localparam logic [31:0] PLC_RST_FN = 32'h0000_0000;
  localparam logic [31:0] PLC_RST_DW = 32'h0000_0000;

endpackage

// file: verilog/plc_top.sv
/*
  Parallel line controller, configuration half: change interrupt, open-drain,
  pull-up, function select and direct-write masking for 32 lines.
  Assumes a single-cycle strobe register port on sys_clk, pins that arrive
  asynchronously, and a drive-enable vector from same-clock logic.
*/
// Functional notes
// R1: writing 1 to change irq enable enables that line's change interrupt
// R2: writing 1 to change irq disable disables that line's change interrupt
// R3: mask register reads 1 for enabled lines, 0 for disabled
// R4: status bit sets on a detected change and holds until read
// R5: reset clears every status bit; a status read clears all but bits set by a change in that same cycle
// R6: writing 1 to open-drain enable turns open-drain on for that line
// R7: writing 1 to open-drain disable turns open-drain off for that line
// R8: open-drain line is only driven low, released for high; status reads 1
// R9: without open-drain, both levels are driven; status reads 0
// R10: writing 1 to pull-up disable switches that pull-up off
// R11: writing 1 to pull-up enable switches that pull-up on
// R12: pull-up status reads 0 when enabled, 1 when disabled
// R13: writing 1 to first-function select routes the line to function one
// R14: writing 1 to second-function select routes the line to function two
// R15: function status reads 0 for first function, 1 for second
// R16: writing 1 to direct-write enable lets level writes change that line
// R17: writing 1 to direct-write disable makes level writes skip that line
// R18: direct-write status reads 1 for updated lines, 0 for skipped ones
// R19: each output level bit is the level driven: 0 low, 1 high
// R20: a change is two differing samples; irq while status and mask both 1
`timescale 1ns/100ps

module plc_top
  import plc_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [PLC_AW-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  // pins and drive control
  input wire logic [PLC_LINES-1:0] line_in,
  input wire logic [PLC_LINES-1:0] line_drive_en,
  output logic [PLC_LINES-1:0] line_out,
  output logic [PLC_LINES-1:0] line_oe,
  output logic [PLC_LINES-1:0] line_pullup_en,
  output logic [PLC_LINES-1:0] line_func_sel,
  // interrupt
  output logic change_irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] level_q;
  logic [31:0] mask_q;
  logic [31:0] stat_q;
  logic [31:0] stat_d;
  logic [31:0] od_q;
  logic [31:0] pu_on_q;
  logic [31:0] fn_q;
  logic [31:0] dw_q;
  logic [31:0] sync1_q;
  logic [31:0] sync2_q;
  logic [31:0] prev_q;
  logic fill1_q;
  logic fill2_q;
  logic fill3_q;
  logic [31:0] chg;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic irq_q;
  logic [PLC_LINES-1:0] out_q;
  logic [PLC_LINES-1:0] oe_q;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = clk_en && bus_wr && (bus_addr == ofs);
  endfunction

  logic rd_stat;
  assign rd_stat = clk_en && bus_rd && (bus_addr == PLC_OFS_IRQ_STAT);

  // ----------------------------------------
  // pin synchroniser and change detect
  // ----------------------------------------
  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= PLC_ZERO;
      sync2_q <= PLC_ZERO;
      prev_q <= PLC_ZERO;
      fill1_q <= 1'b0;
      fill2_q <= 1'b0;
      fill3_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      fill1_q <= 1'b1;
      fill2_q <= fill1_q;
      fill3_q <= fill2_q;
    end
  end

  // pulled-up lines idle high, so compare only once prev_q holds a real sample
  assign chg = (sync2_q ^ prev_q) & {PLC_LINES{fill3_q}}; // R20 R5

  // ----------------------------------------
  // change status, set wins over read clear
  // ----------------------------------------
  always_comb begin
    stat_d = stat_q;
    if (rd_stat) begin
      stat_d = PLC_ZERO; // R5
    end
    stat_d = stat_d | chg; // R4
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= PLC_ZERO; // R5
    end else if (clk_en) begin
      stat_q <= stat_d;
    end
  end

  // ----------------------------------------
  // interrupt mask
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= PLC_RST_MASK;
    end else if (wr_at(PLC_OFS_IRQ_EN)) begin
      mask_q <= mask_q | bus_wdata; // R1
    end else if (wr_at(PLC_OFS_IRQ_DIS)) begin
      mask_q <= mask_q & ~bus_wdata; // R2
    end
  end

  // registered, so the output trails status by one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(stat_q & mask_q); // R20
    end
  end

  // ----------------------------------------
  // open-drain control
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      od_q <= PLC_RST_OD;
    end else if (wr_at(PLC_OFS_OD_EN)) begin
      od_q <= od_q | bus_wdata; // R6
    end else if (wr_at(PLC_OFS_OD_DIS)) begin
      od_q <= od_q & ~bus_wdata; // R7
    end
  end

  // ----------------------------------------
  // pull-up control, stored as enabled bits so the pad output is a flop
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_on_q <= ~PLC_RST_PU_OFF;
    end else if (wr_at(PLC_OFS_PU_DIS)) begin
      pu_on_q <= pu_on_q & ~bus_wdata; // R10
    end else if (wr_at(PLC_OFS_PU_EN)) begin
      pu_on_q <= pu_on_q | bus_wdata; // R11
    end
  end

  // ----------------------------------------
  // function select, 1 means second function
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fn_q <= PLC_RST_FN;
    end else if (wr_at(PLC_OFS_FN_FIRST)) begin
      fn_q <= fn_q & ~bus_wdata; // R13
    end else if (wr_at(PLC_OFS_FN_SECOND)) begin
      fn_q <= fn_q | bus_wdata; // R14
    end
  end

  // ----------------------------------------
  // direct-write mask and output level
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dw_q <= PLC_RST_DW;
    end else if (wr_at(PLC_OFS_DW_EN)) begin
      dw_q <= dw_q | bus_wdata; // R16
    end else if (wr_at(PLC_OFS_DW_DIS)) begin
      dw_q <= dw_q & ~bus_wdata; // R17
    end
  end

  // masked lines keep their level, so drivers can share the register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= PLC_RST_LEVEL;
    end else if (wr_at(PLC_OFS_LEVEL)) begin
      level_q <= (level_q & ~dw_q) | (bus_wdata & dw_q); // R18
    end
  end

  // ----------------------------------------
  // pad drivers
  // ----------------------------------------
  for (genvar i = 0; i < PLC_LINES; i++) begin : g_pad
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        out_q[i] <= 1'b0;
        oe_q[i] <= 1'b0;
      end else if (clk_en) begin
        out_q[i] <= od_q[i] ? 1'b0 : level_q[i]; // R19
        // open-drain releases instead of driving high
        oe_q[i] <= line_drive_en[i] & (~od_q[i] | ~level_q[i]); // R8 R9
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rdata_d = PLC_ZERO;
    case (bus_addr)
      PLC_OFS_LEVEL: rdata_d = level_q;
      PLC_OFS_IRQ_MASK: rdata_d = mask_q; // R3
      PLC_OFS_IRQ_STAT: rdata_d = stat_q; // R4
      PLC_OFS_OD_STAT: rdata_d = od_q; // R8 R9
      PLC_OFS_PU_STAT: rdata_d = ~pu_on_q; // R12
      PLC_OFS_FN_STAT: rdata_d = fn_q; // R15
      PLC_OFS_DW_STAT: rdata_d = dw_q; // R18
      PLC_OFS_PINS: rdata_d = sync2_q;
      default: rdata_d = PLC_ZERO;
    endcase
  end

  // data stand for one enabled cycle after the strobe and hold while clk_en is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= PLC_ZERO;
    end else if (clk_en) begin
      rdata_q <= bus_rd ? rdata_d : PLC_ZERO;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus_rdata = rdata_q;
  assign line_out = out_q;
  assign line_oe = oe_q;
  assign line_pullup_en = pu_on_q; // R12
  assign line_func_sel = fn_q; // R15
  assign change_irq = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr(logic [7:0] ofs);
    clk_en && bus_wr && (bus_addr == ofs);
  endsequence

  sequence s_rd(logic [7:0] ofs);
    clk_en && bus_rd && (bus_addr == ofs);
  endsequence

  a_irq_enable_sets: assert property ( // R1
    s_wr(PLC_OFS_IRQ_EN) |=>
      ((mask_q & $past(bus_wdata)) == $past(bus_wdata)) &&
      ((mask_q & ~$past(bus_wdata)) == ($past(mask_q) & ~$past(bus_wdata))))
    else $error("irq enable write did not set mask bits");

  a_irq_disable_clears: assert property ( // R2
    s_wr(PLC_OFS_IRQ_DIS) |=> mask_q == ($past(mask_q) & ~$past(bus_wdata)))
    else $error("irq disable write did not clear mask bits");

  a_mask_read_back: assert property ( // R3
    s_rd(PLC_OFS_IRQ_MASK) |=> bus_rdata == $past(mask_q))
    else $error("mask read returned wrong value");

  a_status_sticky: assert property ( // R4
    (clk_en && !rd_stat) |=>
      ((stat_q & $past(stat_q)) == $past(stat_q)) &&
      ((stat_q & $past(chg)) == $past(chg)))
    else $error("status bit lost or change not recorded");

  a_status_read_clear: assert property ( // R5
    s_rd(PLC_OFS_IRQ_STAT) |=>
      (bus_rdata == $past(stat_q)) && (stat_q == $past(chg)))
    else $error("status read did not return and clear");

  a_od_enable_sets: assert property ( // R6
    s_wr(PLC_OFS_OD_EN) |=> od_q == ($past(od_q) | $past(bus_wdata)))
    else $error("open-drain enable write wrong");

  a_od_disable_clears: assert property ( // R7
    s_wr(PLC_OFS_OD_DIS) |=> od_q == ($past(od_q) & ~$past(bus_wdata)))
    else $error("open-drain disable write wrong");

  a_od_never_high: assert property ( // R8
    clk_en |=> ((line_oe & line_out & $past(od_q)) == PLC_ZERO) &&
      ((line_oe & $past(od_q) & $past(level_q)) == PLC_ZERO))
    else $error("open-drain line driven high");

  a_push_pull_level: assert property ( // R9
    clk_en |=> ((line_out & ~$past(od_q)) == ($past(level_q) & ~$past(od_q))) &&
      ((line_oe & ~$past(od_q)) == ($past(line_drive_en) & ~$past(od_q))))
    else $error("push-pull line not driven to level");

  a_pullup_disable: assert property ( // R10
    s_wr(PLC_OFS_PU_DIS) |=>
      (line_pullup_en & $past(bus_wdata)) == PLC_ZERO)
    else $error("pull-up disable write did not switch off");

  a_pullup_enable: assert property ( // R11
    s_wr(PLC_OFS_PU_EN) |=>
      (line_pullup_en & $past(bus_wdata)) == $past(bus_wdata))
    else $error("pull-up enable write did not switch on");

  a_pullup_inverted: assert property ( // R12
    s_rd(PLC_OFS_PU_STAT) |=> bus_rdata == ~$past(line_pullup_en))
    else $error("pull-up status sense wrong");

  a_func_first: assert property ( // R13
    s_wr(PLC_OFS_FN_FIRST) |=>
      (line_func_sel & $past(bus_wdata)) == PLC_ZERO)
    else $error("first function select wrong");

  a_func_second: assert property ( // R14
    s_wr(PLC_OFS_FN_SECOND) |=>
      line_func_sel == ($past(line_func_sel) | $past(bus_wdata)))
    else $error("second function select wrong");

  a_func_status: assert property ( // R15
    s_rd(PLC_OFS_FN_STAT) |=> bus_rdata == $past(line_func_sel))
    else $error("function status read wrong");

  a_dw_enable: assert property ( // R16
    s_wr(PLC_OFS_DW_EN) |=> dw_q == ($past(dw_q) | $past(bus_wdata)))
    else $error("direct-write enable wrong");

  a_dw_disable: assert property ( // R17
    s_wr(PLC_OFS_DW_DIS) |=> dw_q == ($past(dw_q) & ~$past(bus_wdata)))
    else $error("direct-write disable wrong");

  a_level_masked_write: assert property ( // R18
    s_wr(PLC_OFS_LEVEL) |=>
      level_q == (($past(level_q) & ~$past(dw_q)) |
                  ($past(bus_wdata) & $past(dw_q))))
    else $error("level write ignored direct-write mask");

  a_level_drives_pin: assert property ( // R19
    (clk_en && od_q == PLC_ZERO) |=> line_out == $past(level_q))
    else $error("pin level differs from output level");

  a_irq_follows: assert property ( // R20
    clk_en |=> change_irq == (|($past(stat_q) & $past(mask_q))))
    else $error("interrupt output disagrees with status and mask");

endmodule // plc_top

// file: test/plc_pin_model.sv
/*
  Pad model for the line controller: resolves each pad from the device
  drive, an external driver and the pull-up.
  Assumes one clock shared with the device.
*/
`timescale 1ns/100ps
module plc_pin_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic [31:0] line_out,
  input wire logic [31:0] line_oe,
  input wire logic [31:0] line_pullup_en,
  // external driver
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_level,
  // pad level
  output logic [31:0] line_in
);
  // ------------------------------
  // pad resolution
  // ------------------------------
  // unpulled, undriven pads wander so no stale level passes for real
  logic [31:0] float_q = 32'h0000_0000;
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (line_oe[i])
        line_in[i] = line_out[i];
      else if (ext_en[i])
        line_in[i] = ext_level[i];
      else if (line_pullup_en[i])
        line_in[i] = 1'b1;
      else
        line_in[i] = float_q[i];
    end
  end
endmodule // plc_pin_model

// file: test/testbench.sv
/*
  Self-checking bench for the line controller configuration block.
  Assumes the register map and reset values of plc_pkg.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  import plc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] drive_en = 32'h0000_0000;
  logic [31:0] ext_en = 32'hFFFF_FFFF;
  logic [31:0] ext_level = 32'h0000_0000;
  logic [31:0] bus_rdata, line_in, line_out, line_oe, line_pullup_en, line_func_sel;
  logic change_irq;
  int errors = 0;
  int n_compared = 0;
  int seed = 78630;
  logic [31:0] m [5];
  logic [31:0] lvl, rd_v, a, b;
  // set, clear and status offsets of each set/clear pair
  logic [7:0] tbl [5][3] = '{'{PLC_OFS_IRQ_EN, PLC_OFS_IRQ_DIS, PLC_OFS_IRQ_MASK},
    '{PLC_OFS_OD_EN, PLC_OFS_OD_DIS, PLC_OFS_OD_STAT},
    '{PLC_OFS_PU_DIS, PLC_OFS_PU_EN, PLC_OFS_PU_STAT},
    '{PLC_OFS_FN_SECOND, PLC_OFS_FN_FIRST, PLC_OFS_FN_STAT},
    '{PLC_OFS_DW_EN, PLC_OFS_DW_DIS, PLC_OFS_DW_STAT}};

  always #2.5 sys_clk = ~sys_clk;

  plc_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .line_in(line_in), .line_drive_en(drive_en), .line_out(line_out), .line_oe(line_oe),
    .line_pullup_en(line_pullup_en), .line_func_sel(line_func_sel),
    .change_irq(change_irq));
  plc_pin_model pads (.clk(sys_clk), .line_out(line_out), .line_oe(line_oe),
    .line_pullup_en(line_pullup_en), .ext_en(ext_en), .ext_level(ext_level),
    .line_in(line_in));

  // ------------------------------
  // bus tasks and expectations
  // ------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= ad;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= ad;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 rd_v = bus_rdata;
    `CHK(rd_v, e)
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  function automatic logic [31:0] f_oe(input logic [31:0] dv, od, lv);
    return dv & (~od | ~lv);
  endfunction
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    foreach (m[i]) m[i] = 32'h0000_0000;
    lvl = 32'h0000_0000;
    do_reset;
    for (int i = 0; i < 5; i++) chk_rd(tbl[i][2], PLC_ZERO);
    chk_rd(PLC_OFS_IRQ_STAT, PLC_ZERO);
    chk_rd(8'hFC, PLC_ZERO);
    `CHK(line_pullup_en, 32'hFFFF_FFFF)
    $display("reset values done");
    for (int i = 0; i < 5; i++) begin
      a = $random(seed);
      b = $random(seed);
      wr(tbl[i][0], a);
      m[i] = m[i] | a;
      chk_rd(tbl[i][2], m[i]);
      wr(tbl[i][1], b);
      m[i] = m[i] & ~b;
      chk_rd(tbl[i][2], m[i]);
    end
    `CHK(line_pullup_en, ~m[2])
    `CHK(line_func_sel, m[3])
    wr(PLC_OFS_IRQ_MASK, $random(seed));
    chk_rd(PLC_OFS_IRQ_MASK, m[0]);
    // a strobe while the clock enable is low must be dropped
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(PLC_OFS_OD_EN, 32'hFFFF_FFFF);
    clk_en <= 1'b1;
    chk_rd(PLC_OFS_OD_STAT, m[1]);
    $display("set and clear done");
    repeat (6) begin
      a = $random(seed);
      wr(PLC_OFS_OD_EN, a);
      m[1] = m[1] | a;
      b = $random(seed);
      wr(PLC_OFS_OD_DIS, b);
      m[1] = m[1] & ~b;
      a = $random(seed);
      drive_en <= $random(seed);
      wr(PLC_OFS_LEVEL, a);
      lvl = (lvl & ~m[4]) | (a & m[4]);
      chk_rd(PLC_OFS_LEVEL, lvl);
      `CHK(line_out, lvl & ~m[1])
      `CHK(line_oe, f_oe(drive_en, m[1], lvl))
    end
    $display("direct write and drive done");
    @(posedge sys_clk);
    drive_en <= 32'h0000_0000;
    repeat (8) @(posedge sys_clk);
    chk_rd(PLC_OFS_IRQ_MASK, m[0]);
    wr(PLC_OFS_IRQ_STAT, 32'hFFFF_FFFF);
    bus_rd <= 1'b1;
    bus_addr <= PLC_OFS_IRQ_STAT;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    a = $random(seed);
    ext_level <= a;
    repeat (6) @(posedge sys_clk);
    #1 `CHK(change_irq, |(a & m[0]))
    chk_rd(PLC_OFS_IRQ_STAT, a);
    chk_rd(PLC_OFS_IRQ_STAT, PLC_ZERO);
    @(posedge sys_clk);
    ext_level <= 32'h0000_0000;
    repeat (6) @(posedge sys_clk);
    // released lines fall back to their pull-up, driven ones stay low
    ext_en <= m[2];
    repeat (4) @(posedge sys_clk);
    chk_rd(PLC_OFS_PINS, ~m[2]);
    do_reset;
    // pins hold their levels across reset, pulled-up ones high: no change may be recorded
    repeat (4) @(posedge sys_clk);
    chk_rd(PLC_OFS_IRQ_STAT, PLC_ZERO);
    $display("change detection done");
    print_verdict;
  end

  initial begin
    #100000;
    errors++;
    print_verdict;
  end
endmodule // testbench
